// ### pqa_core.sv
// Prefetch queue, bus-side unit and execution-side address logic.
// How it works
// RULE1 - Bus-side and execution-side logic run independently, overlapping fetch and execution.
// RULE2 - A 16-bit prefetch offset counter increments per fetched byte.
// RULE3 - Branch, call, return or break loads the counter with the target.
// RULE4 - Opcode fetch addresses always use the program segment base.
// RULE5 - Fetched opcode bytes wait in a six-byte in-order queue.
// RULE6 - Branches and serviced interrupts flush the queue and refetch at target.
// RULE7 - Prefetch starts only with at least two free queue bytes.
// RULE8 - Prefetch uses only idle bus time, yielding to execution requests.
// RULE9 - The bus-side unit runs data cycles requested by execution logic.
// RULE10 - A 16-bit operand pointer holds each computed data offset.
// RULE11 - A 16-bit transfer register has separately accessed upper and lower bytes.
// RULE12 - Writes finish on placement in transfer register; reads on bus data arrival.
// RULE13 - Physical address is segment shifted left four plus offset, unsigned.
// RULE14 - Physical addresses span a one-megabyte 20-bit space.
// RULE15 - Effective address calculation always takes two clocks.
// RULE16 - Operand byte yields effective address into pointer, optionally requesting read.
// RULE17 - A 16-bit iteration counter counts repeats and multi-bit shift counts.
// RULE18 - Multiply/divide shift 32 bits across both shifters; shifts use low only.
// RULE19 - Microcode store holds 1024 words of 29 bits.
// RULE20 - Micro address loads from the first opcode byte of each instruction.
// RULE21 - Standby stops all but bus-hold and wake logic; the code keeps transfer byte writes and write requests running.
// RULE22 - A bus release request floats bus outputs until withdrawn.
// RULE23 - Execution stalls while the queue holds no byte.
// RULE24 - Segment plus offset wraps to 20 bits.
`timescale 1ns/1ns
`include "pqa_defs.svh"
module pqa_core #(
   parameter int DEPTH = `PQA_QUEUE_DEPTH
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   // Control and data from the instruction logic.
   input wire logic BRANCH_I,
   input wire logic INT_SERVICE_I,
   input wire logic [15:0] TARGET_OFS_I,
   input wire logic [15:0] PROG_SEG_I,
   input wire logic [15:0] DATA_SEG_I,
   input wire logic OPCODE_TAKE_I,
   input wire logic INSTR_START_I,
   input wire logic OPERAND_VALID_I,
   input wire logic [7:0] OPERAND_BYTE_I,
   input wire logic [15:0] BASE_I,
   input wire logic [15:0] INDEX_I,
   input wire logic [15:0] DISP_I,
   input wire logic NEED_READ_I,
   input wire logic WRITE_REQ_I,
   input wire logic [1:0] TEMP_BYTE_WE_I,
   input wire logic [15:0] TEMP_WDATA_I,
   input wire logic COUNT_LOAD_I,
   input wire logic [15:0] COUNT_VALUE_I,
   input wire logic COUNT_STEP_I,
   input wire logic SHIFT_LOAD_I,
   input wire logic [31:0] SHIFT_DATA_I,
   input wire logic SHIFT_WIDE_I,
   input wire logic UCODE_NEXT_I,
   input wire logic STANDBY_I,
   input wire logic WAKE_I,
   // External bus.
   input wire logic BUS_READY_I,
   input wire logic [15:0] BUS_DATA_I,
   input wire logic HOLD_REQ_I,
   output logic [19:0] BUS_ADDR_O,
   output logic [15:0] BUS_DATA_O,
   output logic BUS_DATA_OE_O,
   output logic BUS_ADDR_OE_O,
   output logic BUS_STROBE_O,
   output logic BUS_WRITE_O,
   output logic HOLD_ACK_O,
   // Results toward the instruction logic.
   output logic [7:0] OPCODE_O,
   output logic OPCODE_VALID_O,
   output logic [15:0] TEMP_RDATA_O,
   output logic DATA_DONE_O,
   output logic [15:0] OPERAND_PTR_O,
   output logic EA_DONE_O,
   output logic COUNT_ZERO_O,
   output logic [31:0] SHIFT_O,
   output logic [9:0] UADDR_O,
   output logic [28:0] UWORD_O,
   output logic STANDBY_O
);
   // ======================================================
   // Pin synchronisers and standby gating
   // ======================================================
   logic [2:0] hold_sync;
   logic [2:0] ready_sync;
   logic hold_req;
   logic bus_ready;
   logic standby;
   logic run;
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         hold_sync <= 3'h0;
         ready_sync <= 3'h0;
         hold_req <= 1'b0;
      end else begin
         hold_sync <= {hold_sync[1:0], HOLD_REQ_I};
         ready_sync <= {ready_sync[1:0], BUS_READY_I};
         if (hold_sync[1] == hold_sync[2]) begin
            hold_req <= hold_sync[2];
         end
      end
   end
   assign bus_ready = (ready_sync[1] == ready_sync[2]) && ready_sync[2];
   // RULE21 standby gate.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         standby <= 1'b0;
      end else if (WAKE_I) begin
         standby <= 1'b0;
      end else if (STANDBY_I) begin
         standby <= 1'b1;
      end
   end
   // RULE21 queue, bus and execution logic stop; transfer register and write requests keep running.
   assign run = !standby;
   assign STANDBY_O = standby;

   // ======================================================
   // Opcode queue
   // ======================================================
   logic [7:0] queue [DEPTH];
   logic [2:0] rd_ptr;
   logic [2:0] wr_ptr;
   logic [3:0] count;
   logic flush;
   logic push;
   logic pop;
   logic [7:0] push_byte;
   assign flush = run && (BRANCH_I || INT_SERVICE_I);
   // RULE23 stall on empty.
   assign pop = run && OPCODE_TAKE_I && (count != 4'h0) && !flush;
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         rd_ptr <= 3'h0;
         wr_ptr <= 3'h0;
         count <= 4'h0;
      end else if (flush) begin
         // RULE6 queue flush.
         rd_ptr <= 3'h0;
         wr_ptr <= 3'h0;
         count <= 4'h0;
      end else begin
         // RULE5 in-order queue.
         if (push) begin
            wr_ptr <= (wr_ptr == 3'(DEPTH - 1)) ? 3'h0 : wr_ptr + 3'h1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == 3'(DEPTH - 1)) ? 3'h0 : rd_ptr + 3'h1;
         end
         count <= count + {3'h0, push} - {3'h0, pop};
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (push) begin
         queue[wr_ptr] <= push_byte;
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         OPCODE_O <= 8'h00;
         OPCODE_VALID_O <= 1'b0;
      end else begin
         OPCODE_O <= queue[rd_ptr];
         OPCODE_VALID_O <= (count != 4'h0) && !flush && !pop;
      end
   end

   // ======================================================
   // Bus-side unit
   // ======================================================
   pqa_pkg::pqa_bus_e bus_state;
   logic [15:0] prefetch_offset_counter;
   logic [15:0] operand_offset_pointer;
   logic [15:0] transfer;
   logic rd_pend;
   logic wr_pend;
   logic second_byte;
   logic [19:0] fetch_phys;
   logic [19:0] data_phys;
   logic room;
   // RULE7 two bytes free.
   assign room = (count + 4'(`PQA_PREFETCH_ROOM)) <= 4'(DEPTH);
   // RULE4 program segment only.
   pqa_phys_addr u_fetch_addr (
      .seg_i(PROG_SEG_I),
      .ofs_i(prefetch_offset_counter),
      .phys_o(fetch_phys)
   );
   pqa_phys_addr u_data_addr (
      .seg_i(DATA_SEG_I),
      .ofs_i(operand_offset_pointer),
      .phys_o(data_phys)
   );
   assign push = run && !hold_req && (bus_state == pqa_pkg::BUS_FETCH) && bus_ready && !flush;
   assign push_byte = prefetch_offset_counter[0] ? BUS_DATA_I[15:8] : BUS_DATA_I[7:0];
   // RULE1 bus side runs on its own state.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         bus_state <= pqa_pkg::BUS_IDLE;
         prefetch_offset_counter <= `PQA_RESET_OFS;
         second_byte <= 1'b0;
      end else if (flush) begin
         // RULE3 load target.
         prefetch_offset_counter <= TARGET_OFS_I;
         bus_state <= pqa_pkg::BUS_IDLE;
         second_byte <= 1'b0;
      end else if (run && !hold_req) begin
         case (bus_state)
            pqa_pkg::BUS_IDLE: begin
               // A stale answer still in the synchroniser would end the next cycle early.
               if (bus_ready) begin
               // RULE9 execution requests first.
               end else if (wr_pend) begin
                  bus_state <= pqa_pkg::BUS_WRITE;
               end else if (rd_pend) begin
                  bus_state <= pqa_pkg::BUS_READ;
               // RULE8 prefetch when idle.
               end else if (room) begin
                  bus_state <= pqa_pkg::BUS_FETCH;
                  second_byte <= 1'b0;
               end
            end
            pqa_pkg::BUS_FETCH: begin
               if (bus_ready) begin
                  // RULE2 byte increment.
                  prefetch_offset_counter <= prefetch_offset_counter + 16'h0001;
                  second_byte <= !second_byte;
                  if (second_byte || prefetch_offset_counter[0] == 1'b1) begin
                     bus_state <= pqa_pkg::BUS_IDLE;
                  end
               end
            end
            pqa_pkg::BUS_READ, pqa_pkg::BUS_WRITE: begin
               if (bus_ready) begin
                  bus_state <= pqa_pkg::BUS_IDLE;
               end
            end
            default: bus_state <= pqa_pkg::BUS_IDLE;
         endcase
      end
   end
   // RULE22 release bus on hold.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         HOLD_ACK_O <= 1'b0;
         BUS_ADDR_OE_O <= 1'b0;
         BUS_DATA_OE_O <= 1'b0;
         BUS_STROBE_O <= 1'b0;
         BUS_WRITE_O <= 1'b0;
         BUS_ADDR_O <= 20'h00000;
         BUS_DATA_O <= 16'h0000;
      end else begin
         HOLD_ACK_O <= hold_req && (bus_state == pqa_pkg::BUS_IDLE);
         BUS_ADDR_OE_O <= !hold_req;
         BUS_DATA_OE_O <= !hold_req && (bus_state == pqa_pkg::BUS_WRITE);
         BUS_STROBE_O <= !hold_req && run && (bus_state != pqa_pkg::BUS_IDLE);
         BUS_WRITE_O <= bus_state == pqa_pkg::BUS_WRITE;
         BUS_ADDR_O <= (bus_state == pqa_pkg::BUS_FETCH) ? fetch_phys : data_phys;
         BUS_DATA_O <= transfer;
      end
   end

   // ======================================================
   // Transfer register and data requests
   // ======================================================
   logic rd_done;
   assign rd_done = run && (bus_state == pqa_pkg::BUS_READ) && bus_ready && !hold_req;
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         transfer <= 16'h0000;
      end else if (rd_done) begin
         transfer <= BUS_DATA_I;
      end else begin
         // RULE11 byte lanes.
         if (TEMP_BYTE_WE_I[0]) begin
            transfer[7:0] <= TEMP_WDATA_I[7:0];
         end
         if (TEMP_BYTE_WE_I[1]) begin
            transfer[15:8] <= TEMP_WDATA_I[15:8];
         end
      end
   end
   assign TEMP_RDATA_O = transfer;
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         wr_pend <= 1'b0;
         DATA_DONE_O <= 1'b0;
      end else begin
         // RULE12 write done at register, read at bus data.
         DATA_DONE_O <= WRITE_REQ_I || rd_done;
         if (WRITE_REQ_I) begin
            wr_pend <= 1'b1;
         end else if (bus_state == pqa_pkg::BUS_WRITE && bus_ready && !hold_req) begin
            wr_pend <= 1'b0;
         end
      end
   end

   // ======================================================
   // Execution-side unit
   // ======================================================
   pqa_pkg::pqa_exec_e ex_state;
   logic [7:0] operand_byte;
   logic [15:0] ea_partial;
   logic read_wanted;
   logic [15:0] iteration_counter;
   logic [9:0] micro_addr;
   logic [`PQA_UCODE_BITS-1:0] ucode [`PQA_UCODE_WORDS];
   // RULE15 two-clock EA.
   // RULE16 operand byte to pointer.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         ex_state <= pqa_pkg::EX_DECODE;
         operand_byte <= 8'h00;
         ea_partial <= 16'h0000;
         read_wanted <= 1'b0;
         operand_offset_pointer <= 16'h0000;
         rd_pend <= 1'b0;
         EA_DONE_O <= 1'b0;
      end else if (run) begin
         EA_DONE_O <= 1'b0;
         if (rd_done) begin
            rd_pend <= 1'b0;
         end
         case (ex_state)
            pqa_pkg::EX_DECODE: begin
               if (OPERAND_VALID_I) begin
                  operand_byte <= OPERAND_BYTE_I;
                  ea_partial <= BASE_I + INDEX_I;
                  read_wanted <= NEED_READ_I;
                  ex_state <= pqa_pkg::EX_EA;
               end
            end
            pqa_pkg::EX_EA: begin
               // RULE10 pointer load.
               operand_offset_pointer <= ea_partial + DISP_I;
               EA_DONE_O <= 1'b1;
               if (read_wanted) begin
                  rd_pend <= 1'b1;
                  ex_state <= pqa_pkg::EX_WAIT;
               end else begin
                  ex_state <= pqa_pkg::EX_DECODE;
               end
            end
            pqa_pkg::EX_WAIT: begin
               if (rd_done) begin
                  ex_state <= pqa_pkg::EX_DECODE;
               end
            end
            default: ex_state <= pqa_pkg::EX_DECODE;
         endcase
      end
   end
   assign OPERAND_PTR_O = operand_offset_pointer;
   // RULE17 iteration counting.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         iteration_counter <= 16'h0000;
         COUNT_ZERO_O <= 1'b1;
      end else if (run) begin
         if (COUNT_LOAD_I) begin
            iteration_counter <= COUNT_VALUE_I;
            COUNT_ZERO_O <= COUNT_VALUE_I == 16'h0000;
         end else if (COUNT_STEP_I && iteration_counter != 16'h0000) begin
            iteration_counter <= iteration_counter - 16'h0001;
            COUNT_ZERO_O <= iteration_counter == 16'h0001;
         end
      end
   end
   pqa_shifter u_shifter (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .load_i(run && SHIFT_LOAD_I),
      .load_data_i(SHIFT_DATA_I),
      .wide_i(SHIFT_WIDE_I),
      .step_i(run && COUNT_STEP_I),
      .data_o(SHIFT_O)
   );
   // RULE19 microcode store, contents left to the decoder build.
   initial begin
      for (int i = 0; i < `PQA_UCODE_WORDS; i++) begin
         ucode[i] = '0;
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         micro_addr <= 10'h000;
         UWORD_O <= '0;
      end else if (run) begin
         // RULE20 opcode starts sequence.
         if (INSTR_START_I && pop) begin
            micro_addr <= {queue[rd_ptr], 2'b00};
         end else if (UCODE_NEXT_I) begin
            micro_addr <= micro_addr + 10'h001;
         end
         UWORD_O <= ucode[micro_addr];
      end
   end
   assign UADDR_O = micro_addr;
endmodule

// ### pqa_core_asserts.sv
// Checker of port timing for the prefetch queue core.
`timescale 1ns/1ns
module pqa_core_asserts (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic BRANCH_I,
   input wire logic INT_SERVICE_I,
   input wire logic OPCODE_TAKE_I,
   input wire logic INSTR_START_I,
   input wire logic OPERAND_VALID_I,
   input wire logic WRITE_REQ_I,
   input wire logic BUS_DATA_OE_O,
   input wire logic BUS_ADDR_OE_O,
   input wire logic BUS_STROBE_O,
   input wire logic BUS_WRITE_O,
   input wire logic HOLD_ACK_O,
   input wire logic [7:0] OPCODE_O,
   input wire logic OPCODE_VALID_O,
   input wire logic DATA_DONE_O,
   input wire logic EA_DONE_O,
   input wire logic [9:0] UADDR_O,
   input wire logic STANDBY_O
);
   // ==============================
   // Properties.
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   property p_ea; OPERAND_VALID_I && !STANDBY_O |-> ##2 EA_DONE_O; endproperty
   a_ea: assert property (p_ea) else $error("address not done in two cycles");
   property p_ea_cause; EA_DONE_O |-> $past(OPERAND_VALID_I, 2); endproperty
   a_ea_cause: assert property (p_ea_cause) else $error("address done unasked");
   property p_wr; WRITE_REQ_I && !STANDBY_O |=> DATA_DONE_O; endproperty
   a_wr: assert property (p_wr) else $error("write not done next cycle");
   property p_flush; (BRANCH_I || INT_SERVICE_I) && !STANDBY_O |=> !OPCODE_VALID_O; endproperty
   a_flush: assert property (p_flush) else $error("queue not emptied");
   property p_uaddr;
      OPCODE_TAKE_I && INSTR_START_I && OPCODE_VALID_O && !STANDBY_O
      |=> UADDR_O == {$past(OPCODE_O), 2'b00};
   endproperty
   a_uaddr: assert property (p_uaddr) else $error("micro address wrong");
   property p_hold_oe; HOLD_ACK_O |-> !BUS_ADDR_OE_O && !BUS_DATA_OE_O; endproperty
   a_hold_oe: assert property (p_hold_oe) else $error("bus driven in hold");
   property p_hold_stb; HOLD_ACK_O |-> !BUS_STROBE_O; endproperty
   a_hold_stb: assert property (p_hold_stb) else $error("strobe in hold");
   property p_oe_wr; BUS_DATA_OE_O |-> BUS_WRITE_O; endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("data driven on read");
   c_read: cover property (DATA_DONE_O);
   c_hold: cover property (HOLD_ACK_O);
   c_start: cover property (INSTR_START_I && OPCODE_TAKE_I);
endmodule
bind pqa_core pqa_core_asserts u_chk (.CORE_CLK_I, .RST_N_I, .BRANCH_I, .INT_SERVICE_I,
   .OPCODE_TAKE_I, .INSTR_START_I, .OPERAND_VALID_I, .WRITE_REQ_I, .BUS_DATA_OE_O,
   .BUS_ADDR_OE_O, .BUS_STROBE_O, .BUS_WRITE_O, .HOLD_ACK_O, .OPCODE_O, .OPCODE_VALID_O,
   .DATA_DONE_O, .EA_DONE_O, .UADDR_O, .STANDBY_O);

// ### pqa_defs.svh
// Constants of the prefetch queue and address unit.
`ifndef PQA_DEFS_SVH
`define PQA_DEFS_SVH
`define PQA_QUEUE_DEPTH 6
`define PQA_PREFETCH_ROOM 2
`define PQA_EAG_CYCLES 2
`define PQA_SEG_SHIFT 4
`define PQA_PHYS_BITS 20
`define PQA_UCODE_WORDS 1024
`define PQA_UCODE_BITS 29
`define PQA_RESET_SEG 16'hffff
`define PQA_RESET_OFS 16'h0000
`endif

// ### pqa_mem_model.sv
// Memory model answering the core's bus cycles after a set wait.
`timescale 1ns/1ns
module pqa_mem_model (
   input wire logic clk_i,
   input wire logic [19:0] addr_i,
   input wire logic strobe_i,
   input wire logic write_i,
   input wire logic [15:0] wdata_i,
   input wire logic [3:0] wait_i,
   output logic ready_o,
   output logic [15:0] rdata_o,
   output logic [15:0] wdata_o,
   output logic [19:0] waddr_o,
   output logic wseen_o
);
   logic [3:0] cnt = 4'h0;
   function automatic logic [7:0] mb(input logic [19:0] a);
      return a[7:0] ^ a[19:12];
   endfunction
   initial begin
      {ready_o, wseen_o, rdata_o, wdata_o, waddr_o} = '0;
   end
   // ==============================
   // Bus answer.
   // answer bus cycles
   always @(posedge clk_i) begin
      if (!strobe_i) begin
         cnt <= 4'h0;
         ready_o <= 1'b0;
         // Released lines toggle so stale read data can never pass.
         rdata_o <= ~rdata_o;
      end else if (cnt != wait_i) begin
         cnt <= cnt + 4'h1;
      end else begin
         ready_o <= 1'b1;
         rdata_o <= {mb(addr_i | 20'h00001), mb(addr_i & 20'hffffe)};
         if (write_i) begin
            wdata_o <= wdata_i;
            waddr_o <= addr_i;
            wseen_o <= 1'b1;
         end
      end
   end
endmodule

// ### pqa_phys_addr.sv
// Physical address former: segment times sixteen plus offset.
`timescale 1ns/1ns
`include "pqa_defs.svh"
module pqa_phys_addr (
   input wire logic [15:0] seg_i,
   input wire logic [15:0] ofs_i,
   output logic [`PQA_PHYS_BITS-1:0] phys_o
);
   logic [`PQA_PHYS_BITS:0] sum;
   // RULE13 shift and add.
   assign sum = {1'b0, seg_i, 4'h0} + {5'h00, ofs_i};
   // RULE14 RULE24 wrap to 20 bits.
   assign phys_o = sum[`PQA_PHYS_BITS-1:0];
endmodule

// ### pqa_pkg.sv
// Types shared by the prefetch queue and address unit.
package pqa_pkg;
   typedef enum logic [3:0] {
      BUS_IDLE = 4'b0001,
      BUS_FETCH = 4'b0010,
      BUS_READ = 4'b0100,
      BUS_WRITE = 4'b1000
   } pqa_bus_e;
   typedef enum logic [3:0] {
      EX_DECODE = 4'b0001,
      EX_EA = 4'b0010,
      EX_WAIT = 4'b0100,
      EX_RUN = 4'b1000
   } pqa_exec_e;
endpackage

// ### pqa_shifter.sv
// Paired temporary shifters for multiply, divide and shift steps.
`timescale 1ns/1ns
module pqa_shifter (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [31:0] load_data_i,
   input wire logic wide_i,
   input wire logic step_i,
   output logic [31:0] data_o
);
   logic [15:0] temp_shifter_high;
   logic [15:0] temp_shifter_low;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         temp_shifter_high <= 16'h0000;
         temp_shifter_low <= 16'h0000;
      end else if (load_i) begin
         temp_shifter_high <= load_data_i[31:16];
         temp_shifter_low <= load_data_i[15:0];
      end else if (step_i) begin
         // RULE18 wide or low only.
         if (wide_i) begin
            {temp_shifter_high, temp_shifter_low} <= {temp_shifter_high[14:0],
               temp_shifter_low, 1'b0};
         end else begin
            temp_shifter_low <= {temp_shifter_low[14:0], temp_shifter_low[15]};
         end
      end
   end
   assign data_o = {temp_shifter_high, temp_shifter_low};
endmodule

// ### tb_top.sv
// Self-checking bench of the prefetch queue core.
`timescale 1ns/1ns
module tb_top;
   logic CORE_CLK_I = 1'b0, RST_N_I = 1'b0, BRANCH_I = '0, INT_SERVICE_I = '0;
   logic OPCODE_TAKE_I = '0, INSTR_START_I = '0, OPERAND_VALID_I = '0, NEED_READ_I = '0;
   logic WRITE_REQ_I = '0, COUNT_LOAD_I = '0, COUNT_STEP_I = '0, SHIFT_LOAD_I = '0;
   logic SHIFT_WIDE_I = '0, UCODE_NEXT_I = '0, STANDBY_I = '0, WAKE_I = '0, HOLD_REQ_I = '0;
   logic [15:0] TARGET_OFS_I = '0, PROG_SEG_I = 16'h2000, DATA_SEG_I = 16'h3000;
   logic [15:0] BASE_I = 16'h0040, INDEX_I = 16'h0002, DISP_I = 16'h0002;
   logic [15:0] TEMP_WDATA_I = '0, COUNT_VALUE_I = '0;
   logic [7:0] OPERAND_BYTE_I = '0;
   logic [1:0] TEMP_BYTE_WE_I = '0;
   logic [31:0] SHIFT_DATA_I = '0;
   logic [3:0] lat = 4'h1;
   logic BUS_READY_I, BUS_DATA_OE_O, BUS_ADDR_OE_O, BUS_STROBE_O, BUS_WRITE_O, HOLD_ACK_O;
   logic OPCODE_VALID_O, DATA_DONE_O, EA_DONE_O, COUNT_ZERO_O, STANDBY_O, wseen;
   logic [19:0] BUS_ADDR_O, waddr, a;
   logic [15:0] BUS_DATA_I, BUS_DATA_O, TEMP_RDATA_O, OPERAND_PTR_O, wdata;
   logic [7:0] OPCODE_O;
   logic [31:0] SHIFT_O;
   logic [9:0] UADDR_O;
   logic [28:0] UWORD_O;
   int miscompares = 0, checks_done = 0, cycles = 0;
   logic [51:0] rows [5] = '{{16'h0000, 16'h0000, 20'h00000}, {16'hffff, 16'h000f, 20'hfffff},
      {16'hffff, 16'hffff, 20'h0ffef}, {16'h1234, 16'h5678, 20'h179b8},
      {16'h0001, 16'hffff, 20'h1000f}};
   logic [15:0] tgt [2] = '{16'h0100, 16'h0203};
   pqa_core u_dut (.CORE_CLK_I, .RST_N_I, .BRANCH_I, .INT_SERVICE_I, .TARGET_OFS_I,
      .PROG_SEG_I, .DATA_SEG_I, .OPCODE_TAKE_I, .INSTR_START_I, .OPERAND_VALID_I,
      .OPERAND_BYTE_I, .BASE_I, .INDEX_I, .DISP_I, .NEED_READ_I, .WRITE_REQ_I,
      .TEMP_BYTE_WE_I, .TEMP_WDATA_I, .COUNT_LOAD_I, .COUNT_VALUE_I, .COUNT_STEP_I,
      .SHIFT_LOAD_I, .SHIFT_DATA_I, .SHIFT_WIDE_I, .UCODE_NEXT_I, .STANDBY_I, .WAKE_I,
      .BUS_READY_I, .BUS_DATA_I, .HOLD_REQ_I, .BUS_ADDR_O, .BUS_DATA_O, .BUS_DATA_OE_O,
      .BUS_ADDR_OE_O, .BUS_STROBE_O, .BUS_WRITE_O, .HOLD_ACK_O, .OPCODE_O, .OPCODE_VALID_O,
      .TEMP_RDATA_O, .DATA_DONE_O, .OPERAND_PTR_O, .EA_DONE_O, .COUNT_ZERO_O, .SHIFT_O,
      .UADDR_O, .UWORD_O, .STANDBY_O);
   pqa_mem_model u_mem (.clk_i(CORE_CLK_I), .addr_i(BUS_ADDR_O), .strobe_i(BUS_STROBE_O),
      .write_i(BUS_WRITE_O), .wdata_i(BUS_DATA_O), .wait_i(lat), .ready_o(BUS_READY_I),
      .rdata_o(BUS_DATA_I), .wdata_o(wdata), .waddr_o(waddr), .wseen_o(wseen));
   // ==============================
   // Helpers.
   function automatic logic [7:0] mb(input logic [19:0] ad);
      return ad[7:0] ^ ad[19:12];
   endfunction
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge CORE_CLK_I);
      s = 1'b0;
   endtask
   task automatic wt(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 400) begin
         @(negedge CORE_CLK_I);
         n++;
      end
      chk(s, v);
   endtask
   // Pops one byte once it is offered; a stalled queue just makes us wait.
   task automatic take(input logic [19:0] ad, input logic st);
      wt(OPCODE_VALID_O, 1'b1);
      chk(OPCODE_O, mb(ad));
      INSTR_START_I = st;
      pulse(OPCODE_TAKE_I);
      INSTR_START_I = 1'b0;
   endtask
   initial forever #5 CORE_CLK_I = ~CORE_CLK_I;
   always @(posedge CORE_CLK_I) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   // ==============================
   // Main sequence.
   initial begin
      repeat (20) @(negedge CORE_CLK_I);
      chk(COUNT_ZERO_O, 1'b1);
      chk(OPCODE_VALID_O, 1'b0);
      RST_N_I = 1'b1;
      // Data addresses show on the idle bus while it is held.
      HOLD_REQ_I = 1'b1;
      repeat (6) @(negedge CORE_CLK_I);
      pulse(BRANCH_I);
      wt(HOLD_ACK_O, 1'b1);
      INDEX_I = 16'h0000;
      DISP_I = 16'h0000;
      foreach (rows[i]) begin
         {DATA_SEG_I, BASE_I} = rows[i][51:20];
         pulse(OPERAND_VALID_I);
         repeat (2) @(negedge CORE_CLK_I);
         chk(BUS_ADDR_O, rows[i][19:0]);
      end
      HOLD_REQ_I = 1'b0;
      wt(HOLD_ACK_O, 1'b0);
      // Odd target and interrupt flush; the take count keeps the queue even.
      for (int k = 0; k < 2; k++) begin
         TARGET_OFS_I = tgt[k];
         if (k == 0) pulse(BRANCH_I);
         else pulse(INT_SERVICE_I);
         for (int i = 0; i < 8 - k; i++) begin
            take({PROG_SEG_I, 4'h0} + 20'(tgt[k]) + 20'(i), i == 0);
         end
      end
      pulse(UCODE_NEXT_I);
      chk(UADDR_O, {mb({PROG_SEG_I, 4'h0} + 20'(tgt[1])), 2'b00} + 10'h001);
      chk(UWORD_O, 29'h0000000);
      lat = 4'h6;
      repeat (150) @(negedge CORE_CLK_I);
      repeat (10) begin
         @(negedge CORE_CLK_I);
         chk(BUS_STROBE_O, 1'b0);
      end
      a = {PROG_SEG_I, 4'h0} + 20'h0020a;
      for (int i = 0; i < 6; i++) begin
         chk(OPCODE_VALID_O, 1'b1);
         take(a + 20'(i), 1'b0);
         @(negedge CORE_CLK_I);
      end
      chk(OPCODE_VALID_O, 1'b0);
      NEED_READ_I = 1'b1;
      pulse(OPERAND_VALID_I);
      NEED_READ_I = 1'b0;
      wt(DATA_DONE_O, 1'b1);
      a = {DATA_SEG_I, 4'h0} + 20'(OPERAND_PTR_O);
      chk(TEMP_RDATA_O, {mb(a | 20'h00001), mb(a & 20'hffffe)});
      TEMP_WDATA_I = 16'h11aa;
      TEMP_BYTE_WE_I = 2'b01;
      @(negedge CORE_CLK_I);
      TEMP_WDATA_I = 16'hbb22;
      TEMP_BYTE_WE_I = 2'b10;
      @(negedge CORE_CLK_I);
      TEMP_BYTE_WE_I = 2'b00;
      chk(TEMP_RDATA_O, 16'hbbaa);
      pulse(WRITE_REQ_I);
      wt(wseen, 1'b1);
      chk(wdata, 16'hbbaa);
      chk(waddr, a);
      COUNT_VALUE_I = 16'h0002;
      pulse(COUNT_LOAD_I);
      pulse(COUNT_STEP_I);
      chk(COUNT_ZERO_O, 1'b0);
      @(negedge CORE_CLK_I);
      pulse(COUNT_STEP_I);
      @(negedge CORE_CLK_I);
      chk(COUNT_ZERO_O, 1'b1);
      SHIFT_DATA_I = 32'h8001_0203;
      SHIFT_WIDE_I = 1'b1;
      pulse(SHIFT_LOAD_I);
      chk(SHIFT_O, 32'h8001_0203);
      pulse(COUNT_STEP_I);
      chk(SHIFT_O, 32'h0002_0406);
      SHIFT_WIDE_I = 1'b0;
      @(negedge CORE_CLK_I);
      pulse(COUNT_STEP_I);
      chk(SHIFT_O, 32'h0002_080c);
      // Let the refill finish so standby freezes an idle bus.
      repeat (100) @(negedge CORE_CLK_I);
      pulse(STANDBY_I);
      wt(STANDBY_O, 1'b1);
      HOLD_REQ_I = 1'b1;
      wt(HOLD_ACK_O, 1'b1);
      chk(BUS_ADDR_OE_O, 1'b0);
      HOLD_REQ_I = 1'b0;
      wt(HOLD_ACK_O, 1'b0);
      pulse(WAKE_I);
      wt(STANDBY_O, 1'b0);
      RST_N_I = 1'b0;
      repeat (2) @(negedge CORE_CLK_I);
      chk(SHIFT_O, 32'h0000_0000);
      RST_N_I = 1'b1;
      repeat (5) @(negedge CORE_CLK_I);
      stop_test();
   end
endmodule
